// file: inc/vdec_out_pkg.sv
package vdec_out_pkg;
    // --------------------------------------------------------------
    // sizes
    // --------------------------------------------------------------
    localparam int          NUM_FB   = 16;
    localparam int          FB_W     = 4;
    localparam int          NXT_CNT  = 3;
    localparam int          ADDR_W   = 8;
    localparam int          DATA_W   = 32;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0]  A_CMD      = 8'h00;
    localparam logic [7:0]  A_ARG      = 8'h04;
    localparam logic [7:0]  A_STREAM   = 8'h08;
    localparam logic [7:0]  A_DISP_CLR = 8'h0C;
    localparam logic [7:0]  A_INT_EN   = 8'h10;
    localparam logic [7:0]  A_STATUS   = 8'h14;
    localparam logic [7:0]  A_DISP_IDX = 8'h18;
    localparam logic [7:0]  A_DEC_IDX  = 8'h1C;
    localparam logic [7:0]  A_NEXT_IDX = 8'h20;
    localparam logic [7:0]  A_CROP_L   = 8'h24;
    localparam logic [7:0]  A_CROP_R   = 8'h28;
    localparam logic [7:0]  A_CROP_T   = 8'h2C;
    localparam logic [7:0]  A_CROP_B   = 8'h30;
    localparam logic [7:0]  A_SAVE     = 8'h34;
    localparam logic [7:0]  A_FLAGS    = 8'h38;
    localparam logic [7:0]  A_ROT      = 8'h3C;
    localparam logic [7:0]  A_DBK      = 8'h40;
    // --------------------------------------------------------------
    // commands written to A_CMD
    // --------------------------------------------------------------
    localparam logic [3:0]  CMD_START   = 4'h1;
    localparam logic [3:0]  CMD_SEQUENCE_END_COMMAND = 4'h2;
    localparam logic [3:0]  CMD_OPEN    = 4'h3;
    localparam logic [3:0]  CMD_ROTATE  = 4'h4;
    localparam logic [3:0]  CMD_OOB     = 4'h5;
    localparam logic [3:0]  CMD_DBK     = 4'h6;
    // --------------------------------------------------------------
    // interrupt bits, status bits, engine display codes
    // --------------------------------------------------------------
    localparam int          INT_EMPTY  = 1;
    localparam int          INT_DONE   = 3;
    localparam int          ST_BUSY_B  = 4;
    localparam int          ST_EOS_B   = 5;
    localparam logic [1:0]  DC_VALID   = 2'h0;
    localparam logic [1:0]  DC_SKIP    = 2'h1;
    localparam logic [1:0]  DC_NONE    = 2'h2;
    // --------------------------------------------------------------
    // result codes
    // --------------------------------------------------------------
    localparam logic [15:0] IDX_NEG1   = 16'hFFFF;
    localparam logic [15:0] IDX_NEG2   = 16'hFFFE;
    localparam logic [15:0] IDX_NEG3   = 16'hFFFD;
    localparam logic [7:0]  NXT_NONE   = 8'hFF;
    localparam logic [15:0] ZERO16     = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_FLUSH = 3'b100
    } state_t;
endpackage : vdec_out_pkg

// file: rtl/vdec_out_ctrl.sv
`timescale 1ns/1ps
module vdec_out_ctrl
    import vdec_out_pkg::*;
(
    // clock and reset
    input  wire logic                            CLOCK_IN,
    input  wire logic                            RESET_N_IN,
    // register port
    input  wire logic [vdec_out_pkg::ADDR_W-1:0] ADDR_IN,
    input  wire logic [vdec_out_pkg::DATA_W-1:0] WDATA_IN,
    input  wire logic                            WR_IN,
    input  wire logic                            RD_IN,
    output logic      [vdec_out_pkg::DATA_W-1:0] RDATA_OUT,
    // decode engine results
    input  wire logic                            ENG_DONE_IN,
    input  wire logic [1:0]                      ENG_DISP_CODE_IN,
    input  wire logic [vdec_out_pkg::FB_W-1:0]   ENG_DISP_IDX_IN,
    input  wire logic                            ENG_CROP_ON_IN,
    input  wire logic [15:0]                     ENG_CROP_L_IN,
    input  wire logic [15:0]                     ENG_CROP_R_IN,
    input  wire logic [15:0]                     ENG_CROP_T_IN,
    input  wire logic [15:0]                     ENG_CROP_B_IN,
    input  wire logic                            ENG_PS_LACK_IN,
    input  wire logic                            ENG_SLICE_LACK_IN,
    input  wire logic                            ENG_STARVED_IN,
    // decode engine control
    output logic                                 ENG_START_OUT,
    output logic                                 ENG_FLUSH_OUT,
    output logic      [vdec_out_pkg::FB_W-1:0]   ENG_TARGET_OUT,
    output logic                                 ENG_EOS_OUT,
    output logic                                 ENG_FEED_OUT,
    output logic                                 ENG_SEQUENCE_END_COMMAND_OUT,
    output logic                                 ENG_OOB_OUT,
    output logic      [vdec_out_pkg::DATA_W-1:0] ROT_CFG_OUT,
    output logic      [vdec_out_pkg::DATA_W-1:0] DBK_ADDR_OUT,
    // interrupt
    output logic                                 IRQ_OUT
);
    import vdec_out_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    state_t              state_ff,    nxt_state;
    logic [NUM_FB-1:0]   flags_ff,    nxt_flags;
    logic [DATA_W-1:0]   arg_ff,      nxt_arg;
    logic [DATA_W-1:0]   rot_ff,      nxt_rot;
    logic [DATA_W-1:0]   dbk_ff,      nxt_dbk;
    logic [DATA_W-1:0]   int_en_ff,   nxt_int_en;
    logic [DATA_W-1:0]   pend_ff,     nxt_pend;
    logic [15:0]         disp_ff,     nxt_disp;
    logic [15:0]         dec_ff,      nxt_dec;
    logic [23:0]         next_ff,     nxt_next;
    logic [15:0]         crop_l_ff,   nxt_crop_l;
    logic [15:0]         crop_r_ff,   nxt_crop_r;
    logic [15:0]         crop_t_ff,   nxt_crop_t;
    logic [15:0]         crop_b_ff,   nxt_crop_b;
    logic [1:0]          save_ff,     nxt_save;
    logic                eos_ff,      nxt_eos;
    logic                starv_ff;
    logic                start_ff,    nxt_start;
    logic [FB_W-1:0]     target_ff,   nxt_target;
    logic                eos_p_ff,    nxt_eos_p;
    logic                feed_ff,     nxt_feed;
    logic                sequence_end_command_ff,  nxt_sequence_end_command;
    logic                oob_ff,      nxt_oob;
    logic [DATA_W-1:0]   rdata_ff,    nxt_rdata;

    logic [7:0]          free_list [NXT_CNT];
    logic [1:0]          nfound;
    logic                cmd_wr;
    logic [3:0]          cmd;
    logic                busy_done;
    logic [NUM_FB-1:0]   clr_mask;
    logic [NUM_FB-1:0]   set_mask;
    logic [NUM_FB-1:0]   seen_flags;

    assign cmd_wr    = WR_IN && (ADDR_IN == A_CMD);
    assign cmd       = WDATA_IN[3:0];
    assign busy_done = ENG_DONE_IN && (state_ff != ST_IDLE);

    // next indices must skip a buffer flagged for display in this same cycle
    assign clr_mask   = (WR_IN && ADDR_IN == A_DISP_CLR) ?
                        WDATA_IN[NUM_FB-1:0] : '0;
    assign set_mask   = (busy_done && ENG_DISP_CODE_IN == DC_VALID) ?
                        (NUM_FB'(1) << ENG_DISP_IDX_IN) : '0;
    assign seen_flags = (flags_ff & ~clr_mask) | set_mask;

    // --------------------------------------------------------------
    // free buffer search, lowest index first
    // --------------------------------------------------------------
    always_comb
    begin
        nfound = 2'd0;
        for (int k = 0; k < NXT_CNT; k++)
            free_list[k] = NXT_NONE;
        for (int i = 0; i < NUM_FB; i++)
        begin
            if (!seen_flags[i] && nfound != 2'(NXT_CNT))
            begin
                free_list[nfound] = 8'(i);
                nfound = nfound + 2'd1;
            end
        end
    end

    // --------------------------------------------------------------
    // command interpreter
    // --------------------------------------------------------------
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_flags   = flags_ff;
        nxt_arg     = arg_ff;
        nxt_rot     = rot_ff;
        nxt_dbk     = dbk_ff;
        nxt_int_en  = int_en_ff;
        nxt_pend    = pend_ff;
        nxt_disp    = disp_ff;
        nxt_dec     = dec_ff;
        nxt_next    = next_ff;
        nxt_crop_l  = crop_l_ff;
        nxt_crop_r  = crop_r_ff;
        nxt_crop_t  = crop_t_ff;
        nxt_crop_b  = crop_b_ff;
        nxt_save    = save_ff;
        nxt_eos     = eos_ff;
        nxt_start   = 1'b0;
        nxt_target  = target_ff;
        nxt_eos_p   = 1'b0;
        nxt_feed    = 1'b0;
        nxt_sequence_end_command = 1'b0;
        nxt_oob     = 1'b0;

        // software side first, so hardware sets below win over clears
        if (WR_IN)
        begin
            case (ADDR_IN)
                A_ARG:      nxt_arg    = WDATA_IN;
                A_INT_EN:   nxt_int_en = WDATA_IN;
                A_STATUS:   nxt_pend   = pend_ff & ~WDATA_IN;
                A_DISP_CLR: nxt_flags  = flags_ff & ~clr_mask;
                A_STREAM:
                begin
                    if (WDATA_IN == 32'h0000_0000)
                    begin
                        nxt_eos   = 1'b1;
                        nxt_eos_p = 1'b1;
                    end
                    else
                        nxt_feed  = 1'b1;
                end
                default: ;
            endcase
        end

        case (state_ff)
            ST_IDLE:
            begin
                if (cmd_wr)
                begin
                    case (cmd)
                        CMD_START:
                        begin
                            if (eos_ff)
                            begin
                                nxt_start = 1'b1;
                                nxt_state = ST_FLUSH;
                            end
                            else if (nfound != 2'd0)
                            begin
                                nxt_start  = 1'b1;
                                nxt_target = free_list[0][FB_W-1:0];
                                nxt_state  = ST_RUN;
                            end
                            else
                            begin
                                // refused start still completes
                                nxt_dec  = IDX_NEG1;
                                nxt_disp = IDX_NEG3;
                                nxt_pend[INT_DONE] = 1'b1;
                            end
                        end
                        CMD_OPEN:
                        begin
                            nxt_flags = '0;
                            nxt_eos   = 1'b0;
                        end
                        CMD_SEQUENCE_END_COMMAND:
                        begin
                            nxt_sequence_end_command = 1'b1;
                            nxt_eos     = 1'b0;
                        end
                        CMD_ROTATE: nxt_rot = arg_ff;
                        CMD_DBK:    nxt_dbk = arg_ff;
                        CMD_OOB:    nxt_oob = 1'b1;
                        default: ;
                    endcase
                end
            end
            ST_RUN:
            begin
                if (ENG_DONE_IN)
                begin
                    nxt_state = ST_IDLE;
                    nxt_dec   = {{(16-FB_W){1'b0}}, target_ff};
                    nxt_next  = {free_list[2], free_list[1],
                                 free_list[0]};
                    nxt_save  = {ENG_SLICE_LACK_IN, ENG_PS_LACK_IN};
                    case (ENG_DISP_CODE_IN)
                        DC_VALID: nxt_disp = {{(16-FB_W){1'b0}},
                                              ENG_DISP_IDX_IN};
                        DC_SKIP:  nxt_disp = IDX_NEG2;
                        default:  nxt_disp = IDX_NEG3;
                    endcase
                    if (ENG_CROP_ON_IN)
                    begin
                        nxt_crop_l = ENG_CROP_L_IN;
                        nxt_crop_r = ENG_CROP_R_IN;
                        nxt_crop_t = ENG_CROP_T_IN;
                        nxt_crop_b = ENG_CROP_B_IN;
                    end
                    else
                    begin
                        nxt_crop_l = ZERO16;
                        nxt_crop_r = ZERO16;
                        nxt_crop_t = ZERO16;
                        nxt_crop_b = ZERO16;
                    end
                end
            end
            ST_FLUSH:
            begin
                if (ENG_DONE_IN)
                begin
                    // no decode happens here; next indices left stale
                    nxt_state = ST_IDLE;
                    nxt_dec   = IDX_NEG1;
                    if (ENG_DISP_CODE_IN == DC_VALID)
                        nxt_disp = {{(16-FB_W){1'b0}},
                                    ENG_DISP_IDX_IN};
                    else
                        nxt_disp = IDX_NEG1;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase

        if (busy_done)
        begin
            nxt_pend[INT_DONE] = 1'b1;
            if (ENG_DISP_CODE_IN == DC_VALID)
                nxt_flags[ENG_DISP_IDX_IN] = 1'b1;
        end
        if (state_ff == ST_RUN && ENG_STARVED_IN && !starv_ff)
            nxt_pend[INT_EMPTY] = 1'b1;
    end

    // --------------------------------------------------------------
    // register read mux, data one cycle after the strobe
    // --------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = '0;
        if (RD_IN)
        begin
            case (ADDR_IN)
                A_ARG:      nxt_rdata = arg_ff;
                A_INT_EN:   nxt_rdata = int_en_ff;
                A_STATUS:
                begin
                    nxt_rdata = pend_ff;
                    nxt_rdata[ST_BUSY_B] = (state_ff != ST_IDLE);
                    nxt_rdata[ST_EOS_B]  = eos_ff;
                end
                A_DISP_IDX: nxt_rdata = {16'h0000, disp_ff};
                A_DEC_IDX:  nxt_rdata = {16'h0000, dec_ff};
                A_NEXT_IDX: nxt_rdata = {8'h00, next_ff};
                A_CROP_L:   nxt_rdata = {16'h0000, crop_l_ff};
                A_CROP_R:   nxt_rdata = {16'h0000, crop_r_ff};
                A_CROP_T:   nxt_rdata = {16'h0000, crop_t_ff};
                A_CROP_B:   nxt_rdata = {16'h0000, crop_b_ff};
                A_SAVE:     nxt_rdata = {30'h0000_0000, save_ff};
                A_FLAGS:    nxt_rdata = {16'h0000, flags_ff};
                A_ROT:      nxt_rdata = rot_ff;
                A_DBK:      nxt_rdata = dbk_ff;
                default:    nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            state_ff   <= ST_IDLE;
            flags_ff   <= '0;
            arg_ff     <= '0;
            rot_ff     <= '0;
            dbk_ff     <= '0;
            int_en_ff  <= '0;
            pend_ff    <= '0;
            disp_ff    <= IDX_NEG3;
            dec_ff     <= IDX_NEG1;
            next_ff    <= {NXT_NONE, NXT_NONE, NXT_NONE};
            crop_l_ff  <= ZERO16;
            crop_r_ff  <= ZERO16;
            crop_t_ff  <= ZERO16;
            crop_b_ff  <= ZERO16;
            save_ff    <= 2'b00;
            eos_ff     <= 1'b0;
            starv_ff   <= 1'b0;
            start_ff   <= 1'b0;
            target_ff  <= '0;
            eos_p_ff   <= 1'b0;
            feed_ff    <= 1'b0;
            sequence_end_command_ff <= 1'b0;
            oob_ff     <= 1'b0;
            rdata_ff   <= '0;
        end
        else
        begin
            state_ff   <= nxt_state;
            flags_ff   <= nxt_flags;
            arg_ff     <= nxt_arg;
            rot_ff     <= nxt_rot;
            dbk_ff     <= nxt_dbk;
            int_en_ff  <= nxt_int_en;
            pend_ff    <= nxt_pend;
            disp_ff    <= nxt_disp;
            dec_ff     <= nxt_dec;
            next_ff    <= nxt_next;
            crop_l_ff  <= nxt_crop_l;
            crop_r_ff  <= nxt_crop_r;
            crop_t_ff  <= nxt_crop_t;
            crop_b_ff  <= nxt_crop_b;
            save_ff    <= nxt_save;
            eos_ff     <= nxt_eos;
            starv_ff   <= ENG_STARVED_IN;
            start_ff   <= nxt_start;
            target_ff  <= nxt_target;
            eos_p_ff   <= nxt_eos_p;
            feed_ff    <= nxt_feed;
            sequence_end_command_ff <= nxt_sequence_end_command;
            oob_ff     <= nxt_oob;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign RDATA_OUT       = rdata_ff;
    assign ENG_START_OUT   = start_ff;
    assign ENG_FLUSH_OUT   = (state_ff == ST_FLUSH);
    assign ENG_TARGET_OUT  = target_ff;
    assign ENG_EOS_OUT     = eos_p_ff;
    assign ENG_FEED_OUT    = feed_ff;
    assign ENG_SEQUENCE_END_COMMAND_OUT = sequence_end_command_ff;
    assign ENG_OOB_OUT     = oob_ff;
    assign ROT_CFG_OUT     = rot_ff;
    assign DBK_ADDR_OUT    = dbk_ff;
    assign IRQ_OUT         = |(pend_ff & int_en_ff);

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);

    AST_TARGET_FREE: assert property (
        ENG_START_OUT && !ENG_FLUSH_OUT |-> !flags_ff[ENG_TARGET_OUT])
        else $error("write target has display flag set");
    AST_NO_FREE: assert property (
        state_ff == ST_IDLE && cmd_wr && cmd == CMD_START && !eos_ff
        && &flags_ff |=> dec_ff == IDX_NEG1 && state_ff == ST_IDLE
        && !ENG_START_OUT)
        else $error("start without free buffer not refused");
    AST_FLAG_SET: assert property (
        busy_done && ENG_DISP_CODE_IN == DC_VALID
        |=> flags_ff[$past(ENG_DISP_IDX_IN)])
        else $error("display flag not set");
    AST_CROP_ZERO: assert property (
        state_ff == ST_RUN && ENG_DONE_IN && !ENG_CROP_ON_IN
        |=> crop_l_ff == ZERO16 && crop_b_ff == ZERO16)
        else $error("crop window not zero");
    AST_CROP_PASS: assert property (
        state_ff == ST_RUN && ENG_DONE_IN && ENG_CROP_ON_IN
        |=> crop_t_ff == $past(ENG_CROP_T_IN)
        && crop_r_ff == $past(ENG_CROP_R_IN))
        else $error("crop offsets not passed");
    AST_EOS: assert property (
        WR_IN && ADDR_IN == A_STREAM && WDATA_IN == 32'h0000_0000
        |=> ENG_EOS_OUT && eos_ff ##1 !ENG_EOS_OUT)
        else $error("end of stream not signalled");
    AST_FLUSH_END: assert property (
        state_ff == ST_FLUSH && ENG_DONE_IN && ENG_DISP_CODE_IN != DC_VALID
        |=> disp_ff == IDX_NEG1 && dec_ff == IDX_NEG1)
        else $error("flush end index not -1");
    AST_SKIP: assert property (
        state_ff == ST_RUN && ENG_DONE_IN && ENG_DISP_CODE_IN == DC_SKIP
        |=> disp_ff == IDX_NEG2)
        else $error("skip index not -2");
    AST_IRQ_DONE: assert property (
        busy_done && int_en_ff[INT_DONE] && !WR_IN |=> IRQ_OUT)
        else $error("completion interrupt missing");
    AST_OPEN_CLR: assert property (
        state_ff == ST_IDLE && cmd_wr && cmd == CMD_OPEN && !busy_done
        |=> flags_ff == '0)
        else $error("open did not clear flags");

    COV_DECODE: cover property (ENG_START_OUT ##[1:50] busy_done);
    COV_REFUSED: cover property (cmd_wr && cmd == CMD_START && &flags_ff);
    COV_FLUSH: cover property (ENG_EOS_OUT ##[1:50] ENG_FLUSH_OUT);
    COV_STARVE: cover property (IRQ_OUT && pend_ff[INT_EMPTY]);
endmodule : vdec_out_ctrl

// file: tb/eng_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// decode engine stand-in: answers each start after 3 to 6 cycles
// ------------------------------------------------------------------
module eng_model
(
    // clock, reset, request
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    // result to hand back
    input  wire logic [1:0] code_sel_in,
    input  wire logic [3:0] idx_sel_in,
    // result lines
    output logic            done_out,
    output logic [1:0]      code_out,
    output logic [3:0]      idx_out
);
    int cnt;
    int seed = 32'h0000_fdce;
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt <= 0;
            done_out <= 1'b0;
            code_out <= 2'h0;
            idx_out <= 4'h0;
        end
        else
        begin
            // outside done the lines flip so a stale value never passes
            if (!start_in && cnt == 1)
            begin
                done_out <= 1'b1;
                code_out <= code_sel_in;
                idx_out <= idx_sel_in;
            end
            else
            begin
                done_out <= 1'b0;
                code_out <= ~code_out;
                idx_out <= ~idx_out;
            end
            if (start_in)
                cnt <= 3 + ({$random(seed)} % 4);
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule : eng_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import vdec_out_pkg::*;
    logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, crop_on = 0, ps = 0;
    logic sl = 0, starved = 0, done, start, flush, eos, feed, send, oob, irq;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rot, dbk, v, r, ie;
    logic [15:0] cl = 16'h0000, cr = 16'h0000, ct = 16'h0000, cb = 16'h0000;
    logic [15:0] fl = 16'h0000;
    logic [1:0]  m_code = 2'h0, code;
    logic [3:0]  m_idx = 4'h0, didx, tgt, tg;
    logic [5:0]  snap;
    int          miscompares = 0, total_checks = 0, cyc = 0;
    int          seed = 32'h0000_fdce;
    vdec_out_ctrl DUT (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
        .ENG_DONE_IN(done), .ENG_DISP_CODE_IN(code), .ENG_DISP_IDX_IN(didx),
        .ENG_CROP_ON_IN(crop_on), .ENG_CROP_L_IN(cl), .ENG_CROP_R_IN(cr),
        .ENG_CROP_T_IN(ct), .ENG_CROP_B_IN(cb), .ENG_PS_LACK_IN(ps),
        .ENG_SLICE_LACK_IN(sl), .ENG_STARVED_IN(starved),
        .ENG_START_OUT(start), .ENG_FLUSH_OUT(flush), .ENG_TARGET_OUT(tgt),
        .ENG_EOS_OUT(eos), .ENG_FEED_OUT(feed), .ENG_SEQUENCE_END_COMMAND_OUT(send),
        .ENG_OOB_OUT(oob), .ROT_CFG_OUT(rot), .DBK_ADDR_OUT(dbk),
        .IRQ_OUT(irq));
    eng_model ENG (.clk_in(clk), .rst_n_in(rst_n), .start_in(start),
        .code_sel_in(m_code), .idx_sel_in(m_idx), .done_out(done),
        .code_out(code), .idx_out(didx));
    initial forever #50 clk = ~clk;
    always @(posedge clk)
        if (++cyc == 8000)
        begin
            miscompares++;
            end_of_test();
        end
    // ------------------------------------------------------------------
    // bus tasks, checks and expectations
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin miscompares++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp); end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr_s <= 1'b1; @(posedge clk); wr_s <= 1'b0;
        #1 snap = {start, flush, eos, feed, send, oob}; tg = tgt; @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        addr <= a; rd_s <= 1'b1; @(posedge clk); rd_s <= 1'b0;
        #1 v = rdata; @(posedge clk);
    endtask : rd
    task automatic idle();
        for (int n = 0; n < 40; n++)
        begin
            rd(A_STATUS);
            if (v[ST_BUSY_B] === 1'b0) break;
        end
        chk(32'(v[ST_BUSY_B]), 32'h0);
    endtask : idle
    function automatic logic [7:0] lf(input logic [15:0] f);
        for (int i = 0; i < NUM_FB; i++) if (f[i] === 1'b0) return 8'(i);
        return NXT_NONE;
    endfunction : lf
    task automatic dec(input logic [1:0] c, input logic sv);
        logic [7:0] t;
        t = lf(fl);
        m_code <= c; m_idx <= t[3:0]; crop_on <= 1'($random(seed));
        {cl, cb} <= 32'($random(seed)); {cr, ct} <= 32'($random(seed));
        {ps, sl} <= 2'($random(seed)); starved <= 1'b0;
        wr(A_CMD, 32'(CMD_START));
        chk(32'(snap[5]), 32'(t != NXT_NONE));
        if (sv) starved <= 1'b1;
        idle(); rd(A_DEC_IDX);
        if (t == NXT_NONE) begin chk(v, 32'(IDX_NEG1));
            rd(A_DISP_IDX); chk(v, 32'(IDX_NEG3)); end
        else begin chk(32'(tg), 32'(t[3:0]));
            chk(v, 32'(t));
            rd(A_DISP_IDX); chk(v, c == DC_VALID ? 32'(t) : c == DC_SKIP ?
                32'(IDX_NEG2) : 32'(IDX_NEG3));
            if (c == DC_VALID) fl[t[3:0]] = 1'b1;
            rd(A_FLAGS); chk(v, 32'(fl));
            rd(A_CROP_L); chk(v, crop_on ? 32'(cl) : 32'h0);
            rd(A_CROP_B); chk(v, crop_on ? 32'(cb) : 32'h0);
            rd(A_CROP_R); chk(v, crop_on ? 32'(cr) : 32'h0);
            rd(A_CROP_T); chk(v, crop_on ? 32'(ct) : 32'h0);
            rd(A_SAVE); chk(v, 32'({sl, ps}));
            rd(A_NEXT_IDX); chk(32'(v[7:0]), 32'(lf(fl))); end
        rd(A_STATUS); chk(32'(v[INT_DONE]), 32'h1);
        chk(32'(v[INT_EMPTY]), 32'(sv));
        chk(32'(irq), 32'(ie[INT_DONE] | (sv & ie[INT_EMPTY])));
        wr(A_STATUS, 32'h0000_000A); starved <= 1'b0;
    endtask : dec
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1; @(posedge clk);
        rd(A_DISP_IDX); chk(v, 32'(IDX_NEG3));
        rd(A_NEXT_IDX); chk(v, 32'h00FF_FFFF);
        rd(8'hFC); chk(v, 32'h0);
        $display("test reset done");
        wr(A_CMD, 32'(CMD_OPEN)); ie = 32'h0000_000A; wr(A_INT_EN, ie);
        dec(DC_SKIP, 1'b0); dec(DC_NONE, 1'b1); dec(2'h3, 1'b0);
        while (fl !== 16'hFFFF && cyc < 6000) dec(DC_VALID, 1'($random(seed)));
        dec(DC_VALID, 1'b0); // every buffer pending display
        r = $random(seed); wr(A_DISP_CLR, 32'(16'h0001 << r[3:0]));
        fl[r[3:0]] = 1'b0; ie = 32'h0000_0000; wr(A_INT_EN, ie);
        dec(DC_VALID, 1'b1); // masked interrupt, freed buffer reused
        $display("test buffer flags done");
        wr(A_STREAM, 32'h0000_0040); chk(32'(snap[2]), 32'h1);
        wr(A_STREAM, 32'h0000_0000); chk(32'(snap[3]), 32'h1);
        rd(A_STATUS); chk(32'(v[ST_EOS_B]), 32'h1);
        for (int k = 0; k < 2; k++) begin
            m_code <= k ? DC_NONE : DC_VALID; m_idx <= 4'h5;
            wr(A_CMD, 32'(CMD_START)); chk(32'(snap[5:4]), 32'h3);
            idle(); rd(A_DISP_IDX);
            chk(v, k ? 32'(IDX_NEG1) : 32'h0000_0005);
            rd(A_DEC_IDX); chk(v, 32'(IDX_NEG1)); end
        $display("test end of stream done");
        r = $random(seed); wr(A_ARG, r);
        wr(A_CMD, 32'(CMD_ROTATE)); chk(rot, r);
        wr(A_CMD, 32'(CMD_DBK)); chk(dbk, r);
        wr(A_CMD, 32'(CMD_OOB)); chk(32'(snap[0]), 32'h1);
        wr(A_CMD, 32'(CMD_SEQUENCE_END_COMMAND)); chk(32'(snap[1]), 32'h1);
        wr(A_CMD, 32'(CMD_OPEN)); rd(A_FLAGS); chk(v, 32'h0);
        $display("test commands done");
        end_of_test();
    end
endmodule : testbench
